// file: brbm_defs.svh
// Purpose: Address map and constants of the bridge remote buffer memory
// Assumes: Word addressed, 16-bit words
// Notes: Included by package and modules
`ifndef BRBM_DEFS_SVH
`define BRBM_DEFS_SVH
`define BRBM_AW 14
`define BRBM_DW 16
`define BRBM_ADR_RESET 14'h0000
`define BRBM_ADR_SAVE 14'h0001
`define BRBM_ADR_DCHK 14'h0005
`define BRBM_P1_LO 14'h0140
`define BRBM_P1_HI 14'h193f
`define BRBM_LOC_OUT_LO 14'h1940
`define BRBM_LOC_OUT_HI 14'h1a3f
`define BRBM_LOC_IN_LO 14'h1b40
`define BRBM_LOC_IN_HI 14'h1c3f
`define BRBM_P2_LO 14'h1d40
`define BRBM_P2_HI 14'h353f
`define BRBM_BLK_WORDS 6'h30
`define BRBM_LOC_WORDS 9'h100
`define BRBM_REG_RST 16'h0000
`define BRBM_VAL_ONE 16'h0001
`define BRBM_DCHK_MAX 16'h0010
`define BRBM_PAR_DEPTH 12288
`define BRBM_LOC_DEPTH 512
`endif

// file: brbm_host.sv
// Purpose: Network master model and save store of the bridge
// Assumes: Requests change at the falling edge, caller waits for ready
// Notes: Idle bus shows inverted last values
`timescale 1ns/1ps
module brbm_host import brbm_pkg::*; (
  input wire logic CLK,
  output brbm_req_t REQ,
  input wire brbm_rsp_t RSP,
  input wire logic SAVE_START,
  output logic SAVE_DONE
);
  logic [2:0] hold = 3'h0;
  initial REQ = '0;
  initial SAVE_DONE = 1'b0;
  // Stretched so the done level outlives the two-stage sync
  always @(negedge CLK) begin
    hold <= SAVE_START ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
    SAVE_DONE <= SAVE_START || hold != 3'h0;
  end
  task automatic xfer(input logic w, input logic [13:0] a, input logic [15:0] d,
                      output brbm_rsp_t r);
    @(negedge CLK);
    REQ = '{rd: !w, wr: w, addr: a, wdata: d};
    @(negedge CLK);
    r = RSP;
    REQ = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule // brbm_host

// file: brbm_pkg.sv
// Purpose: Types shared by the remote buffer memory
// Assumes: brbm_defs.svh constants
// Notes: Access request and answer carriers
`include "brbm_defs.svh"
package brbm_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`BRBM_AW-1:0] addr;
    logic [`BRBM_DW-1:0] wdata;
  } brbm_req_t;
  typedef struct packed {
    logic valid;
    logic [`BRBM_DW-1:0] rdata;
  } brbm_rsp_t;
  typedef enum logic [2:0] {
    BRBM_IDLE = 3'b001,
    BRBM_SAVE = 3'b010,
    BRBM_DONE = 3'b100
  } brbm_save_st_t;
endpackage

// file: brbm_props.sv
// Purpose: Port checks of the remote buffer memory
// Assumes: One clock, synchronous reset
// Notes: Bound from the bench top
`timescale 1ns/1ps
module brbm_props import brbm_pkg::*; (
  input wire logic CLK,
  input wire logic RST,
  input wire brbm_req_t REQ,
  input wire brbm_rsp_t RSP,
  input wire logic READY,
  input wire logic RESET_REQ,
  input wire logic SAVE_START,
  input wire logic [255:0] WORD_CHECK_MASK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Signals passed in so that sampled values are used, not post-edge ones
  function automatic logic wr_to(input logic rdy, input brbm_req_t q,
                                 input logic [13:0] a, input logic [15:0] d);
    return rdy && q.wr && q.addr == a && q.wdata == d;
  endfunction
  property p_rd_ans; READY && REQ.rd |=> RSP.valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_no_ans; !(READY && REQ.rd) |=> !RSP.valid; endproperty
  a_no_ans: assert property (p_no_ans) else $error("answer without read");
  property p_rst_on; wr_to(READY, REQ, 14'h0000, 16'h0001) |=> RESET_REQ; endproperty
  a_rst_on: assert property (p_rst_on) else $error("reset request not raised");
  property p_rst_off; wr_to(READY, REQ, 14'h0000, 16'h0000) |=> !RESET_REQ; endproperty
  a_rst_off: assert property (p_rst_off) else $error("reset request stuck");
  property p_save; wr_to(READY, REQ, 14'h0001, 16'h0001) |-> ##2 SAVE_START; endproperty
  a_save: assert property (p_save) else $error("save not started");
  property p_mask_all;
    wr_to(READY, REQ, 14'h0005, 16'h0010) |-> ##[1:2] &WORD_CHECK_MASK;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("mask not full");
  property p_mask_none;
    wr_to(READY, REQ, 14'h0005, 16'h0000) |-> ##[1:2] WORD_CHECK_MASK == '0;
  endproperty
  a_mask_none: assert property (p_mask_none) else $error("mask not clear");
  // Word units are always a prefix, never a gap
  property p_mask_pre; WORD_CHECK_MASK[16] |-> WORD_CHECK_MASK[15:0] == 16'hffff; endproperty
  a_mask_pre: assert property (p_mask_pre) else $error("mask has a gap");
  property p_reset;
    disable iff (1'b0) RST |=> !READY && !RSP.valid && !SAVE_START && !RESET_REQ;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  c_read: cover property (READY && REQ.rd);
  c_save: cover property ($rose(SAVE_START));
  c_reset_req: cover property (RESET_REQ);
endmodule // brbm_props

// file: brbm_ram.sv
// Purpose: Word store for parameter areas and location tables
// Assumes: Separate write and read address ports, synchronous read
// Notes: Cleared by the owner after reset
`timescale 1ns/1ps
`include "brbm_defs.svh"
module brbm_ram import brbm_pkg::*; #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [`BRBM_DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [`BRBM_DW-1:0] rdata
);
  logic [`BRBM_DW-1:0] mem_q [DEPTH];
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata <= mem_q[raddr];
  end
endmodule // brbm_ram

// file: brbm_tb_top.sv
// Purpose: Self-checking bench of the remote buffer memory
// Assumes: Clear sweep of 12288 cycles after reset
// Notes: Random data from a fixed-seed shift register
`timescale 1ns/1ps
module brbm_tb_top import brbm_pkg::*;;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic LOC_WE = 1'b0;
  logic [8:0] LOC_ADDR = 9'h000;
  logic [15:0] LOC_WDATA = 16'h0000;
  brbm_req_t REQ;
  brbm_rsp_t RSP, r;
  logic READY, RESET_REQ, SAVE_START, SAVE_DONE;
  logic [255:0] WORD_CHECK_MASK;
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'd75675;
  logic [13:0] adr [8];
  logic [15:0] dat [8];
  always #5 CLK = ~CLK;
  brbm_top u_dut (.CLK(CLK), .RST(RST), .REQ(REQ), .RSP(RSP), .READY(READY),
    .RESET_REQ(RESET_REQ), .SAVE_START(SAVE_START), .SAVE_DONE(SAVE_DONE),
    .WORD_CHECK_MASK(WORD_CHECK_MASK), .LOC_WE(LOC_WE), .LOC_ADDR(LOC_ADDR),
    .LOC_WDATA(LOC_WDATA));
  brbm_host u_host (.CLK(CLK), .REQ(REQ), .RSP(RSP), .SAVE_START(SAVE_START),
    .SAVE_DONE(SAVE_DONE));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [255:0] mask_exp(input int n);
    return (n >= 1 && n <= 16) ? ({256{1'b1}} >> (256 - 16 * n)) : '0;
  endfunction
  function automatic logic [13:0] par_adr(input int m, input int w);
    return (m < 128) ? 14'(320 + m * 48 + w) : 14'(7488 + (m - 128) * 48 + w);
  endfunction
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    u_host.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [13:0] a, input logic [15:0] e);
    u_host.xfer(1'b0, a, 16'h0000, r);
    chk(r, {1'b1, e});
  endtask
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    conclude();
  end
  initial begin
    int i;
    repeat (5) @(posedge CLK);
    @(negedge CLK) RST = 1'b0;
    for (i = 0; i < 13000 && READY !== 1'b1; i++) @(negedge CLK);
    chk(READY, 1'b1);
    rd(14'h0000, 16'h0000);
    rd(14'h0001, 16'h0000);
    rd(14'h0005, 16'h0000);
    wr(14'h0000, 16'h0001);
    chk(RESET_REQ, 1'b1);
    rd(14'h0000, 16'h0001);
    wr(14'h0000, 16'h0000);
    chk(RESET_REQ, 1'b0);
    wr(14'h0001, 16'h0001);
    for (i = 0; i < 10 && SAVE_START !== 1'b1; i++) @(negedge CLK);
    chk(SAVE_START, 1'b1);
    for (i = 0; i < 20 && SAVE_START !== 1'b0; i++) @(negedge CLK);
    repeat (2) @(negedge CLK);
    rd(14'h0001, 16'h0000);
    for (i = 0; i < 18; i++) begin
      wr(14'h0005, 16'(i));
      repeat (3) @(negedge CLK);
      chk(WORD_CHECK_MASK, mask_exp(i));
    end
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      adr[i] = par_adr(i * 32 + int'(seed[4:0]), int'(seed[15:8]) % 48);
      dat[i] = seed[31:16];
    end
    adr[0] = 14'h0140;
    adr[3] = 14'h193f;
    adr[4] = 14'h1d40;
    adr[7] = 14'h353f;
    for (i = 0; i < 8; i++) rd(adr[i], 16'h0000);
    for (i = 0; i < 8; i++) wr(adr[i], dat[i]);
    for (i = 0; i < 8; i++) rd(adr[i], dat[i]);
    @(negedge CLK) {LOC_WE, LOC_ADDR, LOC_WDATA} = {1'b1, 9'h003, 16'h5a3c};
    @(negedge CLK) {LOC_ADDR, LOC_WDATA} = {9'h103, 16'hc3a5};
    @(negedge CLK) LOC_WE = 1'b0;
    rd(14'h1943, 16'h5a3c);
    rd(14'h1b43, 16'hc3a5);
    wr(14'h1943, 16'h0000);
    rd(14'h1943, 16'h5a3c);
    rd(14'h1944, 16'h0000);
    wr(14'h0002, 16'hffff);
    rd(14'h0002, 16'h0000);
    rd(14'h1a40, 16'h0000);
    conclude();
  end
endmodule // brbm_tb_top
bind brbm_top brbm_props u_props (.CLK(CLK), .RST(RST), .REQ(REQ), .RSP(RSP),
  .READY(READY), .RESET_REQ(RESET_REQ), .SAVE_START(SAVE_START),
  .WORD_CHECK_MASK(WORD_CHECK_MASK));

// file: brbm_top.sv
// Purpose: Remote buffer memory of the network-to-sensor-bus bridge
// Assumes: Remote read/write instructions arrive as one-cycle word requests
// Notes: Parameter storage is cleared by a sweep after reset
`timescale 1ns/1ps
`include "brbm_defs.svh"
// Overview of operation
// RQ1: The remote program reaches this memory only by remote buffer read and write by word address.
// RQ2: Word 0 is the remote reset request, 1 asks for a bridge reset, and it starts at 0.
// RQ3: Writing 1 to word 1 saves the settings and the word clears itself when the save is done.
// RQ4: A double-check setting of 0 checks every bit point one bit at a time.
// RQ5: A setting n of 1 to 16 checks the first n words as whole 16-bit words.
// RQ6: For settings 1 to 15 every bit after word n is checked bit by bit.
// RQ7: Parameter area for modules 1 to 128 is read/write at 140h to 193fh and starts at 0.
// RQ8: Parameter area for modules 129 to 256 is read/write at 1d40h to 353fh and starts at 0.
// RQ9: Two read-only location tables sit at 1940h-1a3fh (output) and 1b40h-1c3fh, starting at 0.
// RQ10: Each module block is 48 consecutive words, in ascending module order.
// RQ11: System areas ignore writes and read as undefined data, here zero.
module brbm_top import brbm_pkg::*; (
  input wire logic CLK,
  input wire logic RST,
  input wire brbm_req_t REQ,
  output brbm_rsp_t RSP,
  output logic READY,
  output logic RESET_REQ,
  output logic SAVE_START,
  input wire logic SAVE_DONE,
  output logic [255:0] WORD_CHECK_MASK,
  input wire logic LOC_WE,
  input wire logic [8:0] LOC_ADDR,
  input wire logic [`BRBM_DW-1:0] LOC_WDATA
);
  function automatic logic in_rng(input logic [`BRBM_AW-1:0] a,
                                  input logic [`BRBM_AW-1:0] lo,
                                  input logic [`BRBM_AW-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  logic [`BRBM_DW-1:0] rst_q, rst_d, save_q, save_d, dchk_q, dchk_d;
  brbm_save_st_t st_q, st_d;
  logic [13:0] clr_q, clr_d;
  logic clring;
  logic save_done_s1_q, save_done_s2_q;
  logic [2:0] sel_q, sel_d;
  logic [`BRBM_DW-1:0] reg_rd_q, reg_rd_d;
  logic rd_v_q, rd_v_d;
  logic par_we, loc_we;
  logic [13:0] par_addr;
  logic [8:0] loc_addr;
  logic [`BRBM_DW-1:0] par_wdata, loc_wdata, par_rdata, loc_rdata;
  logic [4:0] nwords;

  assign clring = clr_q != 14'(`BRBM_PAR_DEPTH);
  assign READY = !clring;

  // Slave done pin from another domain
  always_ff @(posedge CLK) begin
    save_done_s1_q <= SAVE_DONE;
    save_done_s2_q <= save_done_s1_q;
  end

  // Parameter store index, both areas back to back in 48-word blocks
  always_comb begin
    par_addr = 14'h0000;
    if (in_rng(REQ.addr, `BRBM_P1_LO, `BRBM_P1_HI)) begin
      par_addr = REQ.addr - `BRBM_P1_LO; // [RQ7] [RQ10]
    end else if (in_rng(REQ.addr, `BRBM_P2_LO, `BRBM_P2_HI)) begin
      par_addr = REQ.addr - `BRBM_P2_LO + (`BRBM_P1_HI - `BRBM_P1_LO + 14'h0001); // [RQ8]
    end
    loc_addr = in_rng(REQ.addr, `BRBM_LOC_IN_LO, `BRBM_LOC_IN_HI)
      ? 9'(REQ.addr - `BRBM_LOC_IN_LO) + `BRBM_LOC_WORDS
      : 9'(REQ.addr - `BRBM_LOC_OUT_LO);
    if (clring) begin
      par_addr = clr_q;
      loc_addr = clr_q[8:0];
    end
  end

  // Clearing sweep zeroes both stores after reset
  always_comb begin
    clr_d = clr_q;
    if (clring) begin
      clr_d = clr_q + 14'h0001;
    end
    par_we = clring || (REQ.wr && (in_rng(REQ.addr, `BRBM_P1_LO, `BRBM_P1_HI)
      || in_rng(REQ.addr, `BRBM_P2_LO, `BRBM_P2_HI))); // [RQ1] [RQ7] [RQ8]
    par_wdata = clring ? `BRBM_REG_RST : REQ.wdata;
    // Table is fed by bridge logic only; remote writes never reach it
    loc_we = (clring && (clr_q < 14'(`BRBM_LOC_DEPTH))) || (!clring && LOC_WE); // [RQ9]
    loc_wdata = clring ? `BRBM_REG_RST : LOC_WDATA;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      clr_q <= 14'h0000;
    end else begin
      clr_q <= clr_d;
    end
  end

  brbm_ram #(.DEPTH(`BRBM_PAR_DEPTH), .AW(14)) u_par (
    .clk(CLK),
    .we(par_we),
    .waddr(par_addr),
    .wdata(par_wdata),
    .raddr(par_addr),
    .rdata(par_rdata)
  );

  brbm_ram #(.DEPTH(`BRBM_LOC_DEPTH), .AW(9)) u_loc (
    .clk(CLK),
    .we(loc_we),
    .waddr(clring ? loc_addr : LOC_ADDR),
    .wdata(loc_wdata),
    .raddr(loc_addr),
    .rdata(loc_rdata)
  );

  // Control words and save sequence
  always_comb begin
    rst_d = rst_q;
    save_d = save_q;
    dchk_d = dchk_q;
    st_d = st_q;
    if (REQ.wr && READY) begin
      case (REQ.addr)
        `BRBM_ADR_RESET: begin
          rst_d = REQ.wdata; // [RQ2]
        end
        `BRBM_ADR_SAVE: begin
          save_d = REQ.wdata;
        end
        `BRBM_ADR_DCHK: begin
          dchk_d = REQ.wdata;
        end
        default: begin
          rst_d = rst_q; // [RQ11]
        end
      endcase
    end
    case (st_q)
      BRBM_IDLE: begin
        if (save_q == `BRBM_VAL_ONE) begin
          st_d = BRBM_SAVE; // [RQ3]
        end
      end
      BRBM_SAVE: begin
        if (save_done_s2_q) begin
          st_d = BRBM_DONE;
        end
      end
      BRBM_DONE: begin
        // A request written in this very cycle must not be lost
        if (!(REQ.wr && READY && (REQ.addr == `BRBM_ADR_SAVE))) begin
          save_d = `BRBM_REG_RST; // [RQ3]
        end
        st_d = BRBM_IDLE;
      end
      default: begin
        st_d = BRBM_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rst_q <= `BRBM_REG_RST;
      save_q <= `BRBM_REG_RST;
      dchk_q <= `BRBM_REG_RST;
      st_q <= BRBM_IDLE;
    end else begin
      rst_q <= rst_d;
      save_q <= save_d;
      dchk_q <= dchk_d;
      st_q <= st_d;
    end
  end

  assign RESET_REQ = rst_q == `BRBM_VAL_ONE; // [RQ2]
  assign SAVE_START = st_q == BRBM_SAVE;

  // Word-checked mask per bit point; out of range treated as all bit-wise
  always_comb begin
    nwords = (dchk_q <= `BRBM_DCHK_MAX) ? dchk_q[4:0] : 5'h00;
    for (int i = 0; i < 256; i++) begin
      WORD_CHECK_MASK[i] = (i / 16) < int'(nwords); // [RQ4] [RQ5] [RQ6]
    end
  end

  // Read path, one cycle after the request
  always_comb begin
    rd_v_d = REQ.rd && READY;
    sel_d = 3'h0;
    reg_rd_d = `BRBM_REG_RST;
    case (REQ.addr)
      `BRBM_ADR_RESET: reg_rd_d = rst_q;
      `BRBM_ADR_SAVE: reg_rd_d = save_q;
      `BRBM_ADR_DCHK: reg_rd_d = dchk_q;
      default: reg_rd_d = `BRBM_REG_RST; // [RQ11]
    endcase
    if (in_rng(REQ.addr, `BRBM_P1_LO, `BRBM_P1_HI)
        || in_rng(REQ.addr, `BRBM_P2_LO, `BRBM_P2_HI)) begin
      sel_d = 3'h1;
    end else if (in_rng(REQ.addr, `BRBM_LOC_OUT_LO, `BRBM_LOC_OUT_HI)
        || in_rng(REQ.addr, `BRBM_LOC_IN_LO, `BRBM_LOC_IN_HI)) begin
      sel_d = 3'h2; // [RQ9]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rd_v_q <= 1'b0;
      sel_q <= 3'h0;
      reg_rd_q <= `BRBM_REG_RST;
    end else begin
      rd_v_q <= rd_v_d;
      sel_q <= sel_d;
      reg_rd_q <= reg_rd_d;
    end
  end

  always_comb begin
    RSP.valid = rd_v_q;
    case (sel_q)
      3'h1: RSP.rdata = par_rdata;
      3'h2: RSP.rdata = loc_rdata;
      default: RSP.rdata = reg_rd_q;
    endcase
  end
endmodule // brbm_top
